/* rtl/tlic_cfg.svh */
// Offsets, field positions, reset values and timing counts
// Assumes inclusion by the controller, the checker and the bench only
`ifndef TLIC_CFG_SVH
`define TLIC_CFG_SVH

// Register offsets
`define TLIC_OFS_MAIN 4'h0
`define TLIC_OFS_RCTL 4'h1
`define TLIC_OFS_CTL2 4'h2
`define TLIC_OFS_STAT 4'h3

// Main control fields
`define TLIC_B_GLOBAL_HIGH_ENABLE 7
`define TLIC_B_GLOBAL_LOW_ENABLE 6
`define TLIC_B_T0IE 5
`define TLIC_B_X0IE 4
`define TLIC_B_PCIE 3
`define TLIC_B_T0IF 2
`define TLIC_B_X0IF 1
`define TLIC_B_PCIF 0

// Reset control and control 2 fields
`define TLIC_B_PRIORITY_MODE_ENABLE 7
`define TLIC_B_EDGE 6
`define TLIC_B_T0IP 2
`define TLIC_B_PCIP 0
`define TLIC_CTL2_MASK 8'h45

// Status fields
`define TLIC_B_INH 1
`define TLIC_B_INL 0

// Reset values
`define TLIC_MAIN_RST 8'h00
`define TLIC_RCTL_RST 8'h00
`define TLIC_CTL2_RST 8'h45

// Vectors
`define TLIC_VEC_HIGH 21'h000008
`define TLIC_VEC_LOW 21'h000018

// Instruction cycles from acceptance to vector load
`define TLIC_ENTRY_CYC 2'h2

`endif

/* rtl/tlic_pkg.sv */
// Types used by the controller only
// Needs nothing from the configuration header
package tlic_pkg;
	typedef enum logic [1:0] {
		TLIC_RUN,
		TLIC_ENTRY
	} tlic_state_t;

	typedef enum logic {
		TLIC_LVL_HIGH,
		TLIC_LVL_LOW
	} tlic_level_t;
endpackage

/* rtl/tlic_ctrl.sv */
// Two-level interrupt controller for a small 8-bit core
// Assumes instr_en pulses once per instruction cycle and
// the core takes stack_push and pc_load in the same cycle
//
// Decided for this implementation: strobed register access and the register offsets.
`include "tlic_cfg.svh"

module tlic_ctrl #(
	parameter int PORT_W = 4,
	parameter int VEC_W  = 21
) (
	input  wire logic              core_clk,
	input  wire logic              rstn,
	input  wire logic [3:0]        reg_addr,
	input  wire logic [7:0]        reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [7:0]        reg_rdata,
	input  wire logic              instr_en,
	input  wire logic              timer_zero_ovf,
	input  wire logic              ext_pin_zero,
	input  wire logic [PORT_W-1:0] upper_port_pins,
	input  wire logic              port_b_read,
	input  wire logic              periph_req_high,
	input  wire logic              periph_req_low,
	input  wire logic              return_from_irq_instr,
	output logic                   irq_pending,
	output logic                   stack_push,
	output logic                   pc_load,
	output logic      [VEC_W-1:0]  pc_vector,
	output logic                   in_high_isr,
	output logic                   in_low_isr
);

	function automatic logic hit(input logic [3:0] a, input logic [3:0] o);
		hit = (a == o);
	endfunction

	logic [7:0]        main_r;
	logic              priority_mode_enable;
	logic [7:0]        ctl2;
	logic [PORT_W-1:0] port_latch;
	logic              pin_prev;
	tlic_pkg::tlic_state_t state;
	tlic_pkg::tlic_level_t lvl;
	logic [1:0]        cnt;

	// Register decode
	wire wr_main = reg_wr && hit(reg_addr, `TLIC_OFS_MAIN);
	wire wr_rctl = reg_wr && hit(reg_addr, `TLIC_OFS_RCTL);
	wire wr_ctl2 = reg_wr && hit(reg_addr, `TLIC_OFS_CTL2);

	wire global_high_enable = main_r[`TLIC_B_GLOBAL_HIGH_ENABLE];
	wire global_low_enable = main_r[`TLIC_B_GLOBAL_LOW_ENABLE];
	wire t0ie = main_r[`TLIC_B_T0IE];
	wire x0ie = main_r[`TLIC_B_X0IE];
	wire pcie = main_r[`TLIC_B_PCIE];
	wire t0if = main_r[`TLIC_B_T0IF];
	wire x0if = main_r[`TLIC_B_X0IF];
	wire pcif = main_r[`TLIC_B_PCIF];

	// Source conditions; only the pin is sampled once per instruction cycle
	// edge select
	wire pin_edge = instr_en && (ctl2[`TLIC_B_EDGE] ?
		(ext_pin_zero && !pin_prev) : (!ext_pin_zero && pin_prev));
	wire mismatch = (upper_port_pins != port_latch);

	wire set_t0 = timer_zero_ovf;
	wire set_x0 = pin_edge;
	// Port read snapshots the pins and ends the mismatch
	wire set_pc = mismatch && !port_b_read;

	// Enabled per-source requests
	wire t0_req = t0if && t0ie;
	wire x0_req = x0if && x0ie;
	wire pc_req = pcif && pcie;

	// priority bits only count in priority mode
	wire t0_high = !priority_mode_enable || ctl2[`TLIC_B_T0IP];
	wire pc_high = !priority_mode_enable || ctl2[`TLIC_B_PCIP];

	wire any_high = x0_req || (t0_req && t0_high) || (pc_req && pc_high) || periph_req_high;
	wire any_low  = (t0_req && !t0_high) || (pc_req && !pc_high) || periph_req_low;

	// bit7 gates high sources in priority mode
	// bit7 clear disables low as well
	// high runs over a low routine
	wire pm_high = global_high_enable && any_high;
	// bit6 gates low sources in priority mode
	// no low while high routine runs
	wire pm_low = global_high_enable && global_low_enable && any_low && !in_high_isr;

	// compat, bit6 gates peripherals, bit7 gates all
	wire cm_core = t0_req || x0_req || pc_req;
	wire cm_per  = global_low_enable && (periph_req_high || periph_req_low);
	wire cm_req  = global_high_enable && (cm_core || cm_per);

	// two-level only with the mode bit set
	// high wins a tie, low stays pending
	wire take_high = priority_mode_enable ? pm_high : cm_req;
	wire take_low  = priority_mode_enable && !pm_high && pm_low;
	wire accept = (state == tlic_pkg::TLIC_RUN) && (take_high || take_low);
	// Entry ends on the second instruction pulse
	wire entry_done = (state == tlic_pkg::TLIC_ENTRY) && instr_en && (cnt == 2'h1);

	assign irq_pending = take_high || take_low;

	wire clr_global_high_enable = accept && take_high;
	wire clr_global_low_enable = accept && !take_high;

	wire ret_high = return_from_irq_instr && in_high_isr;
	wire ret_low  = return_from_irq_instr && !in_high_isr && in_low_isr;
	wire ret_global_low_enable = ret_low && priority_mode_enable;
	wire ret_global_high_enable = ret_high || (ret_low && !priority_mode_enable);

	// Software writes; hardware sets and clears override them
	// enable bits written by software
	// no write guard against memory moves
	wire [7:0] sw_main = wr_main ? {reg_wdata[7:1], pcif} : main_r;

	logic [7:0] next_main;
	always_comb
	begin
		next_main = sw_main;
		if (clr_global_high_enable && !ret_global_high_enable)
			next_main[`TLIC_B_GLOBAL_HIGH_ENABLE] = 1'b0;
		if (ret_global_high_enable)
			next_main[`TLIC_B_GLOBAL_HIGH_ENABLE] = 1'b1;
		if (clr_global_low_enable && !ret_global_low_enable)
			next_main[`TLIC_B_GLOBAL_LOW_ENABLE] = 1'b0;
		if (ret_global_low_enable)
			next_main[`TLIC_B_GLOBAL_LOW_ENABLE] = 1'b1;
		// timer and pin flags set, set wins
		if (set_t0)
			next_main[`TLIC_B_T0IF] = 1'b1;
		if (set_x0)
			next_main[`TLIC_B_X0IF] = 1'b1;
		next_main[`TLIC_B_PCIF] = set_pc || (pcif && !port_b_read);
	end

	always_ff @(posedge core_clk)
	begin
		if (!rstn)
			main_r <= `TLIC_MAIN_RST;
		else
			main_r <= next_main;
	end

	// Reset image of the reset control register
	wire [7:0] rctl_rst = `TLIC_RCTL_RST;

	always_ff @(posedge core_clk)
	begin
		if (!rstn)
		begin
			priority_mode_enable <= rctl_rst[`TLIC_B_PRIORITY_MODE_ENABLE];
			ctl2 <= `TLIC_CTL2_RST;
		end
		else
		begin
			if (wr_rctl)
				priority_mode_enable <= reg_wdata[`TLIC_B_PRIORITY_MODE_ENABLE];
			if (wr_ctl2)
				ctl2 <= reg_wdata & `TLIC_CTL2_MASK;
		end
	end

	// Pin history and port snapshot
	always_ff @(posedge core_clk)
	begin
		if (!rstn)
		begin
			pin_prev   <= 1'b0;
			port_latch <= '0;
		end
		else
		begin
			if (instr_en)
				pin_prev <= ext_pin_zero;
			if (port_b_read)
				port_latch <= upper_port_pins;
		end
	end

	// fixed entry delay in instruction cycles
	tlic_pkg::tlic_state_t next_state;
	tlic_pkg::tlic_level_t next_lvl;
	logic [1:0]            next_cnt;

	always_comb
	begin
		next_state = state;
		next_lvl   = lvl;
		next_cnt   = cnt;
		case (state)
			tlic_pkg::TLIC_RUN:
			begin
				if (accept)
				begin
					next_state = tlic_pkg::TLIC_ENTRY;
					next_lvl   = take_high ? tlic_pkg::TLIC_LVL_HIGH : tlic_pkg::TLIC_LVL_LOW;
					next_cnt   = `TLIC_ENTRY_CYC;
				end
			end
			tlic_pkg::TLIC_ENTRY:
			begin
				if (instr_en)
					next_cnt = cnt - 2'h1;
				if (entry_done)
					next_state = tlic_pkg::TLIC_RUN;
			end
			default:
				next_state = tlic_pkg::TLIC_RUN;
		endcase
	end

	always_ff @(posedge core_clk)
	begin
		if (!rstn)
		begin
			state <= tlic_pkg::TLIC_RUN;
			lvl   <= tlic_pkg::TLIC_LVL_HIGH;
			cnt   <= 2'h0;
		end
		else
		begin
			state <= next_state;
			lvl   <= next_lvl;
			cnt   <= next_cnt;
		end
	end

	// push return address and load vector
	wire [VEC_W-1:0] vec_sel = (lvl == tlic_pkg::TLIC_LVL_HIGH) ?
		VEC_W'(`TLIC_VEC_HIGH) : VEC_W'(`TLIC_VEC_LOW);

	always_ff @(posedge core_clk)
	begin
		if (!rstn)
		begin
			stack_push <= 1'b0;
			pc_load    <= 1'b0;
			pc_vector  <= '0;
		end
		else
		begin
			// Push and load share one pulse
			stack_push <= entry_done;
			pc_load    <= entry_done;
			if (entry_done)
				pc_vector <= vec_sel;
		end
	end

	// Service tracking for nesting and return
	wire enter_high = accept && take_high;
	wire enter_low  = accept && !take_high;

	logic next_in_high;
	logic next_in_low;

	always_comb
	begin
		next_in_high = in_high_isr;
		next_in_low  = in_low_isr;
		if (enter_high)
			next_in_high = 1'b1;
		else if (ret_high)
			next_in_high = 1'b0;
		if (enter_low)
			next_in_low = 1'b1;
		else if (ret_low)
			next_in_low = 1'b0;
	end

	always_ff @(posedge core_clk)
	begin
		if (!rstn)
		begin
			in_high_isr <= 1'b0;
			in_low_isr  <= 1'b0;
		end
		else
		begin
			in_high_isr <= next_in_high;
			in_low_isr  <= next_in_low;
		end
	end

	// Read mux, unmapped reads zero
	wire [7:0] rd_rctl = {priority_mode_enable, 7'h00};
	wire [7:0] rd_stat = {6'h00, in_high_isr, in_low_isr};
	wire [7:0] rd_mux =
		hit(reg_addr, `TLIC_OFS_MAIN) ? main_r :
		hit(reg_addr, `TLIC_OFS_RCTL) ? rd_rctl :
		hit(reg_addr, `TLIC_OFS_CTL2) ? ctl2 :
		hit(reg_addr, `TLIC_OFS_STAT) ? rd_stat : 8'h00;

	// Read data stand one cycle, zero otherwise
	always_ff @(posedge core_clk)
	begin
		if (!rstn)
			reg_rdata <= 8'h00;
		else if (reg_rd)
			reg_rdata <= rd_mux;
		else
			reg_rdata <= 8'h00;
	end

endmodule

/* test/tlic_core_model.sv */
// Core stand-in: instruction-cycle enables and entry count
// Assumes one clock and a synchronous active-low reset
module tlic_core_model (
	input  wire logic core_clk,
	input  wire logic rstn,
	input  wire logic pc_load,
	output logic      instr_en,
	output int        entries
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] phase;

	always_ff @(posedge core_clk)
	begin
		phase <= rstn ? phase + 2'h1 : 2'h0;
		instr_en <= rstn && phase == 2'h3;
		entries <= rstn ? entries + int'(pc_load) : 0;
	end
endmodule

/* test/tlic_ctrl_asserts.sv */
// Checker on the controller ports
// Assumes instr_en pulses at most four clocks apart
`include "tlic_cfg.svh"
module tlic_ctrl_asserts #(
	parameter int PORT_W = 4,
	parameter int VEC_W  = 21
) (
	input wire logic             core_clk,
	input wire logic             rstn,
	input wire logic             return_from_irq_instr,
	input wire logic             irq_pending,
	input wire logic             stack_push,
	input wire logic             pc_load,
	input wire logic [VEC_W-1:0] pc_vector,
	input wire logic             in_high_isr,
	input wire logic             in_low_isr
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking dc @(posedge core_clk);
	endclocking
	default disable iff (!rstn);

	a_vector_level: assert property (
		pc_load |-> (pc_vector == `TLIC_VEC_HIGH && in_high_isr)
		|| (pc_vector == `TLIC_VEC_LOW && in_low_isr && !in_high_isr))
		else $error("vector and routine level disagree");
	a_push_with_load: assert property (
		stack_push == pc_load)
		else $error("push and load apart");
	a_load_single: assert property (
		pc_load |=> !pc_load && !stack_push)
		else $error("load longer than one cycle");
	a_no_low_in_high: assert property (
		in_high_isr |=> !$rose(in_low_isr))
		else $error("low accepted in high routine");
	a_pending_accepted: assert property (
		irq_pending && !in_high_isr && !in_low_isr |=> in_high_isr || in_low_isr)
		else $error("eligible request not accepted");
	a_entry_bounded: assert property (
		$rose(in_high_isr) || $rose(in_low_isr) |-> ##[1:20] pc_load)
		else $error("vector load late");
	a_return_high: assert property (
		return_from_irq_instr && in_high_isr |=> !in_high_isr && $stable(in_low_isr))
		else $error("return left high routine set");
	a_return_low: assert property (
		return_from_irq_instr && !in_high_isr && in_low_isr |=> !in_low_isr)
		else $error("return left low routine set");
endmodule

bind tlic_ctrl tlic_ctrl_asserts #(.PORT_W(PORT_W), .VEC_W(VEC_W)) tlic_ctrl_asserts_i (
	.core_clk, .rstn, .return_from_irq_instr, .irq_pending, .stack_push,
	.pc_load, .pc_vector, .in_high_isr, .in_low_isr);

/* test/two_level_interrupt_controller_bench.sv */
// Bench for the two-level interrupt controller
// Assumes the core model gives instr_en every four clocks
`include "tlic_cfg.svh"
module two_level_interrupt_controller_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        core_clk = 0, rstn = 0, reg_wr = 0, reg_rd = 0;
	logic        tmr = 0, pin = 0, pbr = 0, ret = 0, phi = 0, plo = 0, ien, irq, push, load, hi, lo;
	logic [3:0]  addr = 0, ports = 0;
	logic [7:0]  wdata = 0, rdata;
	logic [20:0] vec;
	int          failures = 0, num_checks = 0, cycles = 0, entries;

	always #2.5 core_clk = ~core_clk;

	tlic_ctrl tlic_ctrl_i (.core_clk, .rstn, .reg_addr(addr), .reg_wdata(wdata), .reg_wr, .reg_rd,
		.reg_rdata(rdata), .instr_en(ien), .timer_zero_ovf(tmr), .ext_pin_zero(pin),
		.upper_port_pins(ports), .port_b_read(pbr), .periph_req_high(phi), .periph_req_low(plo),
		.return_from_irq_instr(ret), .irq_pending(irq), .stack_push(push), .pc_load(load),
		.pc_vector(vec), .in_high_isr(hi), .in_low_isr(lo));
	tlic_core_model tlic_core_model_i (.core_clk, .rstn, .pc_load(load), .instr_en(ien), .entries);

	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	always @(posedge core_clk)
	begin
		cycles++;
		if (cycles == 4000)
		begin
			failures++;
			close_out();
		end
	end

	task automatic chk(input string n, input logic [20:0] e, input logic [20:0] g);
		num_checks++;
		if (g !== e)
		begin
			failures++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_wr <= 1;
		addr <= a;
		wdata <= d;
		@(posedge core_clk);
		reg_wr <= 0;
	endtask

	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge core_clk);
		reg_rd <= 1;
		addr <= a;
		@(posedge core_clk);
		reg_rd <= 0;
		#1;
		chk("reg_rdata", 21'(e), 21'(rdata));
	endtask

	task automatic strobe(input int k);
		@(posedge core_clk);
		tmr <= k == 0;
		pbr <= k == 1;
		ret <= k == 2;
		@(posedge core_clk);
		{tmr, pbr, ret} <= 3'h0;
	endtask

	task automatic wpc(input logic [20:0] e);
		int n;
		n = 0;
		do
		begin
			@(posedge core_clk);
			#1;
			n++;
		end
		while (load !== 1'b1 && n < 40);
		chk("pc_load", 21'h1, 21'(load));
		chk("stack_push", 21'h1, 21'(push));
		chk("pc_vector", e, vec);
	endtask

	task automatic t_reset();
		rd(4'h0, `TLIC_MAIN_RST);
		rd(4'h1, `TLIC_RCTL_RST);
		rd(4'h2, `TLIC_CTL2_RST);
		rd(4'h9, 8'h00);
		$display("reset test done");
	endtask

	task automatic t_compat();
		wr(4'h0, 8'ha0);
		strobe(0);
		wpc(`TLIC_VEC_HIGH);
		rd(4'h0, 8'h24);
		wr(4'h0, 8'h20);
		strobe(2);
		rd(4'h0, 8'ha0);
		chk("isr", 21'h0, 21'({hi, lo}));
		$display("compat test done");
	endtask

	task automatic t_poll();
		wr(4'h0, 8'h00);
		strobe(1);
		pin <= 1;
		ports <= 4'ha;
		repeat (12) @(posedge core_clk);
		rd(4'h0, 8'h03);
		chk("irq_pending", 21'h0, 21'(irq));
		strobe(1);
		rd(4'h0, 8'h02);
		$display("poll test done");
	endtask

	task automatic t_prio();
		wr(4'h1, 8'h80);
		wr(4'h2, 8'h40);
		wr(4'h0, 8'he0);
		strobe(0);
		wpc(`TLIC_VEC_LOW);
		rd(4'h0, 8'ha4);
		wr(4'h0, 8'hb0);
		pin <= 0;
		repeat (12) @(posedge core_clk);
		pin <= 1;
		wpc(`TLIC_VEC_HIGH);
		chk("isr", 21'h3, 21'({hi, lo}));
		wr(4'h0, 8'h30);
		strobe(2);
		rd(4'h0, 8'hb0);
		chk("isr", 21'h1, 21'({hi, lo}));
		strobe(2);
		rd(4'h0, 8'hf0);
		chk("isr", 21'h0, 21'({hi, lo}));
		$display("priority test done");
	endtask

	task automatic t_periph();
		wr(4'h0, 8'h40);
		phi <= 1;
		plo <= 1;
		repeat (12) @(posedge core_clk);
		#1;
		chk("irq_pending", 21'h0, 21'(irq));
		wr(4'h0, 8'h80);
		wpc(`TLIC_VEC_HIGH);
		@(posedge core_clk);
		phi <= 0;
		wr(4'h0, 8'hc0);
		repeat (12) @(posedge core_clk);
		#1;
		chk("irq_pending", 21'h0, 21'(irq));
		strobe(2);
		wpc(`TLIC_VEC_LOW);
		@(posedge core_clk);
		plo <= 0;
		strobe(2);
		rd(4'h0, 8'hc0);
		wr(4'h1, 8'h00);
		wr(4'h0, 8'h80);
		plo <= 1;
		repeat (12) @(posedge core_clk);
		#1;
		chk("irq_pending", 21'h0, 21'(irq));
		wr(4'h0, 8'hc0);
		wpc(`TLIC_VEC_HIGH);
		@(posedge core_clk);
		plo <= 0;
		strobe(2);
		rd(4'h0, 8'hc0);
		chk("isr", 21'h0, 21'({hi, lo}));
		$display("peripheral test done");
	endtask

	initial
	begin
		repeat (5) @(posedge core_clk);
		rstn <= 1;
		t_reset();
		t_compat();
		t_poll();
		t_prio();
		t_periph();
		chk("entries", 21'h6, 21'(entries));
		close_out();
	end
endmodule
